//--- verilog/pm_access.sv
/*
  Program memory partition and table access block with an APB slave.
  Holds a small program memory model, the table page, active partition
  and table read/write mapping. Assumes a single APB master on pclk.
*/
// Decided for this implementation: the placing of the registers and the APB register port.
// Notes on behaviour
// - dual mode: partition with lower boot sequence number becomes active at reset
// - single mode: boot sequence words are ignored
// - new boot sequence numbers take effect only after next reset
// - equal or both corrupted sequence numbers select partition 1
// - one corrupted number: the other partition becomes active
// - swap exchanges partitions now in dual mode only, reset selection unchanged
// - control register bit 10 reads 1 when partition 2 active
// - writes cover 64-word blocks, erases 512-word blocks; code programs one word per command, only reports both sizes
// - program address steps by two per 24-bit word
// - only high operations reach the upper 8 bits
// - every table operation has byte and word forms
// - word read low returns bits 15:0 unchanged
// - byte read low picks upper byte when byte select is 1
// - word read high returns bits 23:16, upper data byte zero
// - byte read high with byte select 1 returns zero
// - page bit 7 picks user space at 0, configuration at 1
// - table writes refused in configuration space
module pm_access
  import pm_access_pkg::*;
#(
  parameter int MEM_WORDS = 256
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int IDX_W = $clog2(MEM_WORDS);

  // ---------------------------------------------------------------
  // storage and registers
  // ---------------------------------------------------------------
  logic [7:0] tbl_page_r;
  logic [15:0] seq1_r;
  logic [15:0] seq2_r;
  logic dual_r;
  logic swapped_r;
  logic refused_r;
  logic done_r;
  logic [15:0] rdata_r;
  logic [31:0] prdata_r;
  logic part2_sel;
  logic sel_done;

  logic [31:0] prdata_nxt;
  logic [1:0][PWORD_W-1:0] part_word;
  logic wr_en;
  logic rd_setup;
  logic wr_page;
  logic wr_seq;
  logic wr_mode;
  logic wr_ctrl;
  logic wr_data;
  logic cmd_go;
  tbl_op_e cmd_op;
  logic cmd_byte;
  logic [15:0] cmd_addr;
  logic [15:0] cmd_wdata;
  logic [IDX_W-1:0] widx;
  logic byte_sel;
  logic cfg_space;
  logic p2_active;
  logic [PWORD_W-1:0] pword;
  logic [15:0] rd_val;
  logic is_write;

  assign wr_en = psel && penable && pwrite;
  // read data is fetched in the setup cycle so that it stands in the access cycle
  assign rd_setup = psel && !penable && !pwrite;
  // register write strobes, each active in the access cycle only
  assign wr_page = wr_en && (paddr == OFF_TBL_PAGE);
  assign wr_seq = wr_en && (paddr == OFF_BOOT_SEQ);
  assign wr_mode = wr_en && (paddr == OFF_PART_CFG);
  assign wr_ctrl = wr_en && (paddr == OFF_NVM_CTRL);
  assign wr_data = wr_en && (paddr == OFF_TBL_DATA);
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = prdata_r;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  // command word: op[1:0], byte[2], wdata[15:0] at bits 15:0 of data
  // register, address offset at bits 31:16
  assign cmd_go = wr_en && (paddr == OFF_TBL_CMD);
  assign cmd_op = tbl_op_e'(pwdata[CMD_OP_LSB +: 2]);
  assign cmd_byte = pwdata[CMD_BYTE_BIT];
  assign cmd_addr = pwdata[CMD_ADDR_LSB +: 16];
  assign cmd_wdata = rdata_r;
  // bit 0 is byte select, bits above step in twos per program word
  assign byte_sel = cmd_addr[0];
  assign widx = cmd_addr[IDX_W:1];
  assign cfg_space = tbl_page_r[TBL_PAGE_CFG_BIT];
  assign p2_active = part2_sel ^ swapped_r;
  assign is_write = (cmd_op == OP_WRITE_LOW) || (cmd_op == OP_WRITE_HIGH);

  // configuration words are not held here: they read as erased flash
  always_comb begin
    pword = PWORD_ERASED;
    if (!cfg_space) begin
      pword = part_word[p2_active];
    end
  end

  // ---------------------------------------------------------------
  // table read data mapping
  // ---------------------------------------------------------------
  always_comb begin
    rd_val = 16'h0000;
    unique case (cmd_op)
      OP_READ_LOW: begin
        if (!cmd_byte) begin
          rd_val = pword[15:0];
        end else if (byte_sel) begin
          rd_val = {8'h00, pword[15:8]};
        end else begin
          rd_val = {8'h00, pword[7:0]};
        end
      end
      OP_READ_HIGH: begin
        if (!cmd_byte) begin
          rd_val = {8'h00, pword[23:16]};
        end else if (byte_sel) begin
          rd_val = 16'h0000;
        end else begin
          rd_val = {8'h00, pword[23:16]};
        end
      end
      OP_WRITE_LOW, OP_WRITE_HIGH: begin
        rd_val = rdata_r;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // reset-time partition selection
  // ---------------------------------------------------------------
  boot_select u_boot_select (
    .pclk(pclk),
    .presetn(presetn),
    .seq_part1(seq1_r),
    .seq_part2(seq2_r),
    .dual_mode(dual_r),
    .part2_selected(part2_sel),
    .select_done(sel_done)
  );

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_page_r <= TBL_PAGE_RST;
    end else if (wr_page) begin
      tbl_page_r <= pwdata[7:0];
    end
  end

  // boot sequence words and mode live in flash: kept across reset
  always_ff @(posedge pclk) begin
    if (wr_seq) begin
      seq1_r <= pwdata[15:0];
      seq2_r <= pwdata[31:16];
    end
    if (wr_mode) begin
      dual_r <= pwdata[CFG_DUAL_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swapped_r <= 1'b0;
    end else if (wr_ctrl && pwdata[NVM_SWAP_BIT] && dual_r) begin
      swapped_r <= ~swapped_r;
    end
  end

  // ---------------------------------------------------------------
  // table operation execution
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 16'h0000;
      refused_r <= 1'b0;
      done_r <= 1'b0;
    end else if (cmd_go) begin
      rdata_r <= rd_val;
      refused_r <= is_write && cfg_space;
      done_r <= 1'b1;
    end else if (wr_data) begin
      rdata_r <= pwdata[15:0];
    end
  end

  // ---------------------------------------------------------------
  // partition storage, one word array per physical partition
  // ---------------------------------------------------------------
  // one word is programmed per command; block programming is outside this model
  for (genvar g = 0; g < 2; g++) begin : g_part
    logic [PWORD_W-1:0] words [MEM_WORDS];
    logic wr_here;

    // only the active partition takes table writes, never configuration space
    assign wr_here = cmd_go && is_write && !cfg_space && (p2_active == 1'(g));
    assign part_word[g] = words[widx];

    always_ff @(posedge pclk) begin
      if (wr_here) begin
        words[widx] <= wr_word(words[widx]);
      end
    end
  end

  function automatic logic [PWORD_W-1:0] wr_word(input logic [PWORD_W-1:0] old);
    logic [PWORD_W-1:0] w;
    w = old;
    if (cmd_op == OP_WRITE_LOW) begin
      if (!cmd_byte) begin
        w[15:0] = cmd_wdata;
      end else if (byte_sel) begin
        w[15:8] = cmd_wdata[7:0];
      end else begin
        w[7:0] = cmd_wdata[7:0];
      end
    end else if (!cmd_byte || !byte_sel) begin
      w[23:16] = cmd_wdata[7:0];
    end
    return w;
  endfunction

  // ---------------------------------------------------------------
  // apb read mux
  // ---------------------------------------------------------------
  always_comb begin
    prdata_nxt = 32'h00000000;
    unique case (paddr)
      OFF_NVM_CTRL: begin
        prdata_nxt[NVM_P2_ACTIVE_BIT] = p2_active;
      end
      OFF_TBL_PAGE: begin
        prdata_nxt[7:0] = tbl_page_r;
      end
      OFF_TBL_DATA: begin
        prdata_nxt[15:0] = rdata_r;
      end
      OFF_TBL_STAT: begin
        prdata_nxt[STAT_REFUSED_BIT] = refused_r;
        prdata_nxt[STAT_DONE_BIT] = done_r;
        prdata_nxt[8] = sel_done;
        // block sizes for software that plans programming and erasing
        prdata_nxt[15:9] = 7'(WRITE_BLOCK_WORDS);
        prdata_nxt[31:16] = 16'(ERASE_BLOCK_WORDS);
      end
      OFF_BOOT_SEQ: begin
        prdata_nxt = {seq2_r, seq1_r};
      end
      OFF_PART_CFG: begin
        prdata_nxt[CFG_DUAL_BIT] = dual_r;
      end
      default: begin
        prdata_nxt = 32'h00000000;
      end
    endcase
  end

  // read data is loaded at the end of the setup cycle and stands from the access cycle until the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_r <= prdata_nxt;
    end
  end
endmodule

//--- verilog/pm_access_pkg.sv
/*
  Constants for the program memory access block: APB register offsets,
  field positions, reset values, table operation codes and block sizes.
  Assumes a 32-bit APB bus and the block running on pclk.
*/
package pm_access_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_NVM_CTRL = 12'h000;
  localparam logic [11:0] OFF_TBL_PAGE = 12'h004;
  localparam logic [11:0] OFF_TBL_CMD = 12'h008;
  localparam logic [11:0] OFF_TBL_DATA = 12'h00C;
  localparam logic [11:0] OFF_TBL_STAT = 12'h010;
  localparam logic [11:0] OFF_BOOT_SEQ = 12'h014;
  localparam logic [11:0] OFF_PART_CFG = 12'h018;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int NVM_P2_ACTIVE_BIT = 10;
  localparam int NVM_SWAP_BIT = 0;
  localparam int TBL_PAGE_CFG_BIT = 7;
  localparam int CMD_BYTE_BIT = 2;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_ADDR_LSB = 16;
  localparam int STAT_REFUSED_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int CFG_DUAL_BIT = 0;
  // ---------------------------------------------------------------
  // widths, reset values, block sizes
  // ---------------------------------------------------------------
  localparam int PWORD_W = 24;
  localparam int PADDR_W = 24;
  localparam logic [7:0] TBL_PAGE_RST = 8'h00;
  localparam logic [15:0] BOOT_SEQ_RST = 16'hFFFF;
  localparam int WRITE_BLOCK_WORDS = 64;
  localparam int ERASE_BLOCK_WORDS = 512;
  localparam logic [23:0] PWORD_ERASED = 24'hFFFFFF;
  // ---------------------------------------------------------------
  // table operations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_READ_LOW = 2'h0,
    OP_READ_HIGH = 2'h1,
    OP_WRITE_LOW = 2'h2,
    OP_WRITE_HIGH = 2'h3
  } tbl_op_e;
endpackage

//--- verilog/boot_select.sv
/*
  Reset-time partition selection from the two boot sequence words.
  Assumes the words are stable while the selection runs after reset.
*/
module boot_select
  import pm_access_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // boot sequence words of both partitions and the dual mode setting
  input wire logic [15:0] seq_part1,
  input wire logic [15:0] seq_part2,
  input wire logic dual_mode,
  // selection result
  output logic part2_selected,
  output logic select_done
);
  logic valid1;
  logic valid2;
  logic pick2;

  // a word is sound when its upper byte is the complement of the lower
  assign valid1 = (seq_part1[15:8] == ~seq_part1[7:0]);
  assign valid2 = (seq_part2[15:8] == ~seq_part2[7:0]);

  always_comb begin
    pick2 = 1'b0;
    if (dual_mode) begin
      if (valid1 && valid2) begin
        pick2 = (seq_part2[7:0] < seq_part1[7:0]);
      end else if (valid2 && !valid1) begin
        pick2 = 1'b1;
      end else begin
        pick2 = 1'b0;
      end
    end else begin
      pick2 = 1'b0;
    end
  end

  // decision taken once, in the first cycle after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      part2_selected <= 1'b0;
      select_done <= 1'b0;
    end else if (!select_done) begin
      part2_selected <= pick2;
      select_done <= 1'b1;
    end
  end
endmodule

//--- tb/pm_access_properties.sv
/*
  Checker on the pm_access APB ports.
  Assumes a master that keeps the setup/access order.
*/
module pm_access_properties
  import pm_access_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [7:0] page_r;
  logic [15:0] mask_r;
  logic [31:0] seq_r;
  logic refused_r, seq_ok_r, wr_acc, rd_setup;
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  // ------
  // shadows of written state
  // ------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_r <= TBL_PAGE_RST;
      mask_r <= 16'h0000;
      seq_r <= 32'h0;
      refused_r <= 1'b0;
      seq_ok_r <= 1'b0;
    end else if (wr_acc && paddr == OFF_TBL_PAGE) begin
      page_r <= pwdata[7:0];
    end else if (wr_acc && paddr == OFF_BOOT_SEQ) begin
      seq_r <= pwdata;
      seq_ok_r <= 1'b1;
    end else if (wr_acc && paddr == OFF_TBL_CMD) begin
      // write ops have op bit 1 set; high reads mask the phantom byte
      refused_r <= pwdata[1] && page_r[TBL_PAGE_CFG_BIT];
      mask_r <= (pwdata[1:0] != OP_READ_HIGH) ? 16'h0000 : !pwdata[CMD_BYTE_BIT] ? 16'hFF00
        : pwdata[CMD_ADDR_LSB] ? 16'h00FF : 16'h0000;
    end
  end
  sequence s_rd(logic [11:0] a);
    rd_setup && paddr == a ##1 penable;
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_no_error: assert property (!pslverr)
    else $error("pslverr high");
  a_rdata_hold: assert property ($changed(prdata) |-> $past(rd_setup))
    else $error("prdata moved outside a read");
  a_unmapped_zero: assert property (rd_setup && paddr > OFF_PART_CFG |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_page_readback: assert property (s_rd(OFF_TBL_PAGE) |-> prdata[7:0] == page_r)
    else $error("page readback wrong");
  a_phantom_zero: assert property (
    s_rd(OFF_TBL_DATA) |-> (prdata[15:0] & mask_r) == 16'h0000)
    else $error("phantom byte not zero");
  a_write_refused: assert property (
    s_rd(OFF_TBL_STAT) ##0 refused_r |-> prdata[STAT_REFUSED_BIT])
    else $error("config write not refused");
  a_seq_readback: assert property (s_rd(OFF_BOOT_SEQ) ##0 seq_ok_r |-> prdata == seq_r)
    else $error("boot words readback wrong");
endmodule

bind pm_access pm_access_properties i_pm_access_properties (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));

//--- tb/core_model.sv
/*
  Stand-in for the processor core: issues register accesses as an APB
  master. Assumes pready is sampled at rising pclk edges.
*/
module core_model
(
  // clock
  input wire logic pclk,
  // apb master side
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0,
  input wire logic [31:0] prdata,
  input wire logic pready
);
  timeunit 1ns;
  timeprecision 1ps;
  // one transfer, entered just after a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

//--- tb/test_program_memory_partition_table_access.sv
/*
  Self-checking bench for pm_access: boot selection, swap, table reads
  and writes, page and refusal. Assumes core_model drives the APB.
*/
module test_program_memory_partition_table_access
  import pm_access_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [23:0] w;
  logic [15:0] a, m;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  // boot cases: word valid when its upper byte inverts its lower byte
  localparam logic [15:0] SEQ1 [7] = '{16'hFC03, 16'hFA05, 16'hFB04, 16'h1234,
    16'h1234, 16'hF609, 16'hFA05};
  localparam logic [15:0] SEQ2 [7] = '{16'hFA05, 16'hFC03, 16'hFB04, 16'h0000,
    16'hF609, 16'h0000, 16'hFC03};
  localparam logic [6:0] DUAL = 7'b0111111;
  localparam logic [6:0] EXP_P2 = 7'b0010010;
  initial forever #10 pclk = ~pclk;
  pm_access #(.MEM_WORDS(256)) i_pm_access (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  core_model i_core_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
  // ------
  // helpers
  // ------
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    i_core_model.xfer(1'b1, ad, d, q);
  endtask
  task automatic rd(input logic [11:0] ad);
    i_core_model.xfer(1'b0, ad, 32'h0, q);
  endtask
  task automatic cmd(input logic [1:0] op, input logic byt, input logic [15:0] ad);
    wr(OFF_TBL_CMD, {ad, 13'h0000, byt, op});
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  function automatic logic [15:0] exp_rd(logic [23:0] pw, logic hi, logic byt, logic sel);
    if (!hi) return byt ? {8'h00, sel ? pw[15:8] : pw[7:0]} : pw[15:0];
    return (byt && sel) ? 16'h0000 : {8'h00, pw[23:16]};
  endfunction
  task automatic tally_and_finish;
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // ------
  // scenarios
  // ------
  initial begin
    void'($urandom(32'h3F4F));
    do_reset();
    rd(12'h01C);
    chk(q, 32'h0, "unmapped read");
    rd(OFF_TBL_PAGE);
    chk(q[7:0], TBL_PAGE_RST, "page reset value");
    for (int i = 0; i < 7; i++) begin
      wr(OFF_PART_CFG, {31'h0, DUAL[i]});
      wr(OFF_BOOT_SEQ, {SEQ2[i], SEQ1[i]});
      rd(OFF_BOOT_SEQ);
      chk(q, {SEQ2[i], SEQ1[i]}, "boot words readback");
      rd(OFF_NVM_CTRL);
      if (i > 0) chk(q[NVM_P2_ACTIVE_BIT], EXP_P2[i-1] ^ DUAL[i-1], "moved before reset");
      do_reset();
      rd(OFF_NVM_CTRL);
      chk(q[NVM_P2_ACTIVE_BIT], EXP_P2[i], "reset selection");
      wr(OFF_NVM_CTRL, 32'h1);
      rd(OFF_NVM_CTRL);
      chk(q[NVM_P2_ACTIVE_BIT], EXP_P2[i] ^ DUAL[i], "swap result");
    end
    for (int j = 0; j < 16; j++) begin
      a = (j == 0) ? 16'h0000 : (j == 1) ? 16'h01FE : {7'h00, 8'($urandom_range(0, 255)), 1'b0};
      w = 24'($urandom);
      wr(OFF_TBL_DATA, {16'h0000, w[15:0]});
      cmd(OP_WRITE_LOW, 1'b0, a);
      wr(OFF_TBL_DATA, {24'h000000, w[23:16]});
      cmd(OP_WRITE_HIGH, 1'b0, a);
      for (int k = 0; k < 8; k++) begin
        cmd(k[2] ? OP_READ_HIGH : OP_READ_LOW, k[1], a | {15'h0000, k[0]});
        rd(OFF_TBL_DATA);
        m = k[1] ? 16'h00FF : 16'hFFFF;
        chk(q[15:0] & m, exp_rd(w, k[2], k[1], k[0]) & m, "table read");
      end
    end
    wr(OFF_TBL_PAGE, 32'h80);
    rd(OFF_TBL_PAGE);
    chk(q[7:0], 8'h80, "page readback");
    wr(OFF_TBL_DATA, 32'h0000A55A);
    cmd(OP_WRITE_LOW, 1'b0, a);
    rd(OFF_TBL_STAT);
    chk(q[STAT_REFUSED_BIT], 1'b1, "config write accepted");
    chk({q[8], q[STAT_DONE_BIT]}, 2'b11, "selection or command not done");
    chk(q[31:9], {16'(ERASE_BLOCK_WORDS), 7'(WRITE_BLOCK_WORDS)}, "block sizes");
    cmd(OP_READ_LOW, 1'b0, a);
    rd(OFF_TBL_DATA);
    chk(q[15:0], PWORD_ERASED[15:0], "config low word not erased");
    cmd(OP_READ_HIGH, 1'b0, a);
    rd(OFF_TBL_DATA);
    chk(q[15:0], {8'h00, PWORD_ERASED[23:16]}, "config high word wrong");
    wr(OFF_TBL_PAGE, 32'h0);
    cmd(OP_READ_LOW, 1'b0, a);
    rd(OFF_TBL_DATA);
    chk(q[15:0], w[15:0], "user word changed");
    tally_and_finish();
  end
endmodule
